/* src/imu_pkg.sv */
package imu_pkg;

    // operand and result widths
    localparam int WORD_W   = 16;
    localparam int PROD_W   = 32;
    localparam int ACC_W    = 40;
    localparam int LIT_W    = 5;
    localparam int REG_IDX_W = 4;

    // result written one cycle after the request is taken
    localparam int LATENCY_CYCLES = 1;

    // reset values
    localparam logic [WORD_W-1:0]    WORD_RST = 16'h0000;
    localparam logic [ACC_W-1:0]     ACC_RST  = 40'h00_0000_0000;
    localparam logic [REG_IDX_W-1:0] IDX_RST  = 4'h0;
    localparam logic [7:0]           FLAGS_RST = 8'h00;

    // operand signedness: bit 1 base, bit 0 source
    typedef enum logic [1:0] {
        IMU_SGN_UU = 2'h0,
        IMU_SGN_US = 2'h1,
        IMU_SGN_SU = 2'h2,
        IMU_SGN_SS = 2'h3
    } imu_sign_type;

    // destination of the product
    typedef enum logic [1:0] {
        IMU_DST_PAIR   = 2'h0,
        IMU_DST_SINGLE = 2'h1,
        IMU_DST_ACC    = 2'h3
    } imu_dest_type;

endpackage

/* src/imu_core_mult.sv */
`timescale 1ns/100ps
`default_nettype none

// combinational 17x17 signed multiplier; operands carry their own extension bit
module imu_core_mult (
    // extended operands
    input  wire logic signed [imu_pkg::WORD_W:0]   op_a,
    input  wire logic signed [imu_pkg::WORD_W:0]   op_b,
    // full product, low 32 bits are the documented product
    output logic signed [2*imu_pkg::WORD_W+1:0]    prod
);

    // one signed array covers all four signedness mixes
    always_comb begin
        prod = op_a * op_b;
    end

endmodule

`default_nettype wire

/* src/imu_mult_unit.sv */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RQ1 - signed times signed, pair destination
// RQ2 - signed base, unsigned source, pair destination
// RQ3 - unsigned base, signed source, pair destination
// RQ4 - unsigned times unsigned, pair destination
// RQ5 - all four mixes may target accumulator
// RQ6 - 5-bit unsigned literal source to accumulator
// RQ7 - single-register result for all mixes
// RQ8 - every form completes in one cycle
// RQ9 - status flags never changed by multiply
// RQ10 - literal forms may write single register
// RQ11 - accumulator extension signed if either signed
module imu_mult_unit (
    // clock and reset
    input  wire logic                              sys_clk,
    input  wire logic                              rst_b,
    // request from decoder
    input  wire logic                              req_valid,
    input  wire imu_pkg::imu_sign_type             req_sign,
    input  wire imu_pkg::imu_dest_type             req_dest,
    input  wire logic                              req_use_lit,
    input  wire logic [imu_pkg::LIT_W-1:0]         short_unsigned_literal,
    input  wire logic [imu_pkg::WORD_W-1:0]        base_operand_register,
    input  wire logic [imu_pkg::WORD_W-1:0]        source_operand_register,
    input  wire logic [imu_pkg::REG_IDX_W-1:0]     req_dst_idx,
    input  wire logic                              req_acc_sel,
    // status flags seen by the unit, passed through untouched
    input  wire logic [7:0]                        flags_in,
    // working register write ports (low and high half)
    output logic                                   wr_lo_en,
    output logic [imu_pkg::REG_IDX_W-1:0]          wr_lo_idx,
    output logic [imu_pkg::WORD_W-1:0]             wr_lo_data,
    output logic                                   wr_hi_en,
    output logic [imu_pkg::REG_IDX_W-1:0]          wr_hi_idx,
    output logic [imu_pkg::WORD_W-1:0]             wr_hi_data,
    // accumulator write port
    output logic                                   acc_wr_en,
    output logic                                   acc_wr_sel,
    output logic [imu_pkg::ACC_W-1:0]              acc_wr_data,
    // status flags after the instruction
    output logic [7:0]                             flags_out,
    output logic                                   flags_wr_en
);

    // extended operands and raw product
    logic signed [imu_pkg::WORD_W:0]       op_a;
    logic signed [imu_pkg::WORD_W:0]       op_b;
    logic signed [2*imu_pkg::WORD_W+1:0]   prod_full;
    logic [imu_pkg::WORD_W-1:0]            src_val;
    logic                                  any_signed;
    logic [imu_pkg::PROD_W-1:0]            prod;

    // registered outputs and their next values
    logic                                  wr_lo_en_r, wr_lo_en_nxt;
    logic [imu_pkg::REG_IDX_W-1:0]         wr_lo_idx_r, wr_lo_idx_nxt;
    logic [imu_pkg::WORD_W-1:0]            wr_lo_data_r, wr_lo_data_nxt;
    logic                                  wr_hi_en_r, wr_hi_en_nxt;
    logic [imu_pkg::REG_IDX_W-1:0]         wr_hi_idx_r, wr_hi_idx_nxt;
    logic [imu_pkg::WORD_W-1:0]            wr_hi_data_r, wr_hi_data_nxt;
    logic                                  acc_wr_en_r, acc_wr_en_nxt;
    logic                                  acc_wr_sel_r, acc_wr_sel_nxt;
    logic [imu_pkg::ACC_W-1:0]             acc_wr_data_r, acc_wr_data_nxt;
    logic [7:0]                            flags_r, flags_nxt;

    // extend a word as signed or unsigned
    function automatic logic signed [imu_pkg::WORD_W:0] ext_word(
        input logic [imu_pkg::WORD_W-1:0] w,
        input logic                       sgn
    );
        ext_word = {sgn & w[imu_pkg::WORD_W-1], w};
    endfunction

    // operand selection and extension
    always_comb begin
        // literal is always unsigned, zero-extended to a word
        src_val = req_use_lit ? {11'h000, short_unsigned_literal}   // RQ6 RQ10
                              : source_operand_register;
        op_a = ext_word(base_operand_register, req_sign[1]);   // RQ1 RQ2 RQ3 RQ4
        op_b = ext_word(src_val, req_sign[0] & ~req_use_lit);   // RQ1 RQ2 RQ3 RQ4
        any_signed = req_sign[1] | (req_sign[0] & ~req_use_lit);
    end

    // shared multiplier array
    imu_core_mult u_mult (
        .op_a (op_a),
        .op_b (op_b),
        .prod (prod_full)
    );

    assign prod = prod_full[imu_pkg::PROD_W-1:0];

    // next-state for the result ports
    always_comb begin
        wr_lo_en_nxt    = 1'b0;
        wr_lo_idx_nxt   = wr_lo_idx_r;
        wr_lo_data_nxt  = wr_lo_data_r;
        wr_hi_en_nxt    = 1'b0;
        wr_hi_idx_nxt   = wr_hi_idx_r;
        wr_hi_data_nxt  = wr_hi_data_r;
        acc_wr_en_nxt   = 1'b0;
        acc_wr_sel_nxt  = acc_wr_sel_r;
        acc_wr_data_nxt = acc_wr_data_r;
        // flags are always carried through unchanged
        flags_nxt = flags_in;   // RQ9
        if (req_valid) begin
            // the result lands in the next cycle, no stall
            case (req_dest)   // RQ8
                imu_pkg::IMU_DST_PAIR: begin
                    wr_lo_en_nxt   = 1'b1;   // RQ1 RQ2 RQ3 RQ4
                    wr_lo_idx_nxt  = req_dst_idx;
                    wr_lo_data_nxt = prod[imu_pkg::WORD_W-1:0];
                    wr_hi_en_nxt   = 1'b1;
                    // high half goes one register up; wraps at the top index
                    wr_hi_idx_nxt  = req_dst_idx + 4'h1;
                    wr_hi_data_nxt = prod[imu_pkg::PROD_W-1:imu_pkg::WORD_W];
                end
                imu_pkg::IMU_DST_SINGLE: begin
                    wr_lo_en_nxt   = 1'b1;   // RQ7 RQ10
                    wr_lo_idx_nxt  = req_dst_idx;
                    wr_lo_data_nxt = prod[imu_pkg::WORD_W-1:0];
                end
                imu_pkg::IMU_DST_ACC: begin
                    acc_wr_en_nxt   = 1'b1;   // RQ5 RQ6
                    acc_wr_sel_nxt  = req_acc_sel;
                    // sign bit of the product only meaningful if an operand was signed
                    acc_wr_data_nxt = {{(imu_pkg::ACC_W-imu_pkg::PROD_W)
                                       {any_signed & prod[imu_pkg::PROD_W-1]}}, prod};   // RQ11
                end
                default: begin
                    // unused destination code: nothing written
                    wr_lo_en_nxt = 1'b0;
                end
            endcase
        end
    end

    // result registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_lo_en_r    <= 1'b0;
            wr_lo_idx_r   <= imu_pkg::IDX_RST;
            wr_lo_data_r  <= imu_pkg::WORD_RST;
            wr_hi_en_r    <= 1'b0;
            wr_hi_idx_r   <= imu_pkg::IDX_RST;
            wr_hi_data_r  <= imu_pkg::WORD_RST;
            acc_wr_en_r   <= 1'b0;
            acc_wr_sel_r  <= 1'b0;
            acc_wr_data_r <= imu_pkg::ACC_RST;
            flags_r       <= imu_pkg::FLAGS_RST;
        end else begin
            wr_lo_en_r    <= wr_lo_en_nxt;
            wr_lo_idx_r   <= wr_lo_idx_nxt;
            wr_lo_data_r  <= wr_lo_data_nxt;
            wr_hi_en_r    <= wr_hi_en_nxt;
            wr_hi_idx_r   <= wr_hi_idx_nxt;
            wr_hi_data_r  <= wr_hi_data_nxt;
            acc_wr_en_r   <= acc_wr_en_nxt;
            acc_wr_sel_r  <= acc_wr_sel_nxt;
            acc_wr_data_r <= acc_wr_data_nxt;
            flags_r       <= flags_nxt;
        end
    end

    // outputs straight from flops
    assign wr_lo_en    = wr_lo_en_r;
    assign wr_lo_idx   = wr_lo_idx_r;
    assign wr_lo_data  = wr_lo_data_r;
    assign wr_hi_en    = wr_hi_en_r;
    assign wr_hi_idx   = wr_hi_idx_r;
    assign wr_hi_data  = wr_hi_data_r;
    assign acc_wr_en   = acc_wr_en_r;
    assign acc_wr_sel  = acc_wr_sel_r;
    assign acc_wr_data = acc_wr_data_r;
    assign flags_out   = flags_r;
    // the unit never asks for a flag update
    assign flags_wr_en = 1'b0;   // RQ9

    // ---- checks ----
    a_ss_pair_prod: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ1
        req_valid && req_dest == imu_pkg::IMU_DST_PAIR && !req_use_lit
        && req_sign == imu_pkg::IMU_SGN_SS
        |=> $signed({wr_hi_data, wr_lo_data})
            == $signed($past(base_operand_register)) * $signed($past(source_operand_register)))
        else $error("signed pair product wrong");

    a_su_pair_prod: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ2
        req_valid && req_dest == imu_pkg::IMU_DST_PAIR && !req_use_lit
        && req_sign == imu_pkg::IMU_SGN_SU
        |=> $signed({wr_hi_data, wr_lo_data}) == 32'(
            $signed({{16{$past(base_operand_register[15])}}, $past(base_operand_register)})
            * $signed({16'h0000, $past(source_operand_register)})))
        else $error("signed-unsigned pair product wrong");

    a_us_pair_prod: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ3
        req_valid && req_dest == imu_pkg::IMU_DST_PAIR && !req_use_lit
        && req_sign == imu_pkg::IMU_SGN_US
        |=> {wr_hi_data, wr_lo_data} == 32'(
            $signed({16'h0000, $past(base_operand_register)})
            * $signed({{16{$past(source_operand_register[15])}}, $past(source_operand_register)})))
        else $error("unsigned-signed pair product wrong");

    a_uu_pair_prod: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ4
        req_valid && req_dest == imu_pkg::IMU_DST_PAIR && !req_use_lit
        && req_sign == imu_pkg::IMU_SGN_UU
        |=> wr_lo_en && wr_hi_en && wr_hi_idx == 4'($past(req_dst_idx) + 4'h1)
            && {wr_hi_data, wr_lo_data}
               == 32'($past(base_operand_register)) * 32'($past(source_operand_register)))
        else $error("unsigned pair product wrong");

    a_acc_dest_only: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ5
        req_valid && req_dest == imu_pkg::IMU_DST_ACC
        |=> acc_wr_en && !wr_lo_en && !wr_hi_en && acc_wr_sel == $past(req_acc_sel))
        else $error("accumulator form wrote wrong target");

    a_lit_uu_acc: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ6
        req_valid && req_dest == imu_pkg::IMU_DST_ACC && req_use_lit
        && req_sign == imu_pkg::IMU_SGN_UU
        |=> acc_wr_data == 40'($past(base_operand_register)) * 40'($past(short_unsigned_literal)))
        else $error("literal accumulator product wrong");

    a_single_dest: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ7
        req_valid && req_dest == imu_pkg::IMU_DST_SINGLE
        |=> wr_lo_en && !wr_hi_en && !acc_wr_en && wr_lo_idx == $past(req_dst_idx))
        else $error("single form wrote wrong target");

    a_one_cycle_done: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ8
        !req_valid |=> !wr_lo_en && !wr_hi_en && !acc_wr_en)
        else $error("write without request one cycle earlier");

    a_flags_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ9
        ##1 (flags_out == $past(flags_in) && !flags_wr_en))
        else $error("multiply altered status flags");

    a_acc_extend: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RQ11
        acc_wr_en && $past(req_sign) == imu_pkg::IMU_SGN_UU
        |-> acc_wr_data[39:32] == 8'h00)
        else $error("unsigned accumulator result not zero-extended");

endmodule

`default_nettype wire

/* testbench/imu_regfile_model.sv */
`timescale 1ns/100ps
`default_nettype none

// stand-in for the working registers and accumulators that take the unit's writes
module imu_regfile_model (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // working register writes, low and high half
    input  wire logic        wr_lo_en,
    input  wire logic [3:0]  wr_lo_idx,
    input  wire logic [15:0] wr_lo_data,
    input  wire logic        wr_hi_en,
    input  wire logic [3:0]  wr_hi_idx,
    input  wire logic [15:0] wr_hi_data,
    // accumulator write
    input  wire logic        acc_wr_en,
    input  wire logic        acc_wr_sel,
    input  wire logic [39:0] acc_wr_data
);
    logic [15:0] regs [16]; // working registers
    logic [39:0] accs [2];  // two accumulators

    // writes land on the edge that ends the pulse, as a real file would take them
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            regs <= '{default: 16'h0000};
            accs <= '{default: 40'h00_0000_0000};
        end else begin
            if (wr_lo_en) begin
                regs[wr_lo_idx] <= wr_lo_data;
            end
            if (wr_hi_en) begin
                regs[wr_hi_idx] <= wr_hi_data;
            end
            if (acc_wr_en) begin
                accs[acc_wr_sel] <= acc_wr_data;
            end
        end
    end
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic        sys_clk, rst_b, req_valid, req_use_lit, req_acc_sel; // bench drives
    imu_pkg::imu_sign_type req_sign;    // operand mix
    imu_pkg::imu_dest_type req_dest;    // destination
    logic [4:0]  lit;                   // short literal
    logic [15:0] op_a, op_b;            // operands
    logic [3:0]  dst_idx;               // destination index
    logic [7:0]  flags_in, flags_out;   // status flags
    logic        wr_lo_en, wr_hi_en, acc_wr_en, acc_wr_sel, flags_wr_en; // enables
    logic [3:0]  wr_lo_idx, wr_hi_idx;  // write indices
    logic [15:0] wr_lo_data, wr_hi_data; // write data
    logic [39:0] acc_wr_data;           // accumulator data
    int          fail_count, n_checks, cycles;

    imu_mult_unit imu_mult_unit_i (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_sign(req_sign), .req_dest(req_dest), .req_use_lit(req_use_lit),
        .short_unsigned_literal(lit), .base_operand_register(op_a),
        .source_operand_register(op_b), .req_dst_idx(dst_idx), .req_acc_sel(req_acc_sel),
        .flags_in(flags_in), .wr_lo_en(wr_lo_en), .wr_lo_idx(wr_lo_idx),
        .wr_lo_data(wr_lo_data), .wr_hi_en(wr_hi_en), .wr_hi_idx(wr_hi_idx),
        .wr_hi_data(wr_hi_data), .acc_wr_en(acc_wr_en), .acc_wr_sel(acc_wr_sel),
        .acc_wr_data(acc_wr_data), .flags_out(flags_out), .flags_wr_en(flags_wr_en));

    imu_regfile_model imu_regfile_model_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .wr_lo_en(wr_lo_en), .wr_lo_idx(wr_lo_idx), .wr_lo_data(wr_lo_data),
        .wr_hi_en(wr_hi_en), .wr_hi_idx(wr_hi_idx), .wr_hi_data(wr_hi_data),
        .acc_wr_en(acc_wr_en), .acc_wr_sel(acc_wr_sel), .acc_wr_data(acc_wr_data));

    // 200 MHz core clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // hang guard: the whole run needs well under 200 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 500) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // reference product, extended to accumulator width when either side is signed
    function automatic logic [39:0] ref_prod(input logic sb, input logic ss,
                                             input logic [15:0] a, input logic [15:0] b);
        logic signed [33:0] p;
        p = $signed({sb & a[15], a}) * $signed({ss & b[15], b});
        return {{8{(sb | ss) & p[31]}}, p[31:0]};
    endfunction

    // present one request; flags are tied to the low byte of the base operand so they change when that byte does
    task automatic put(input logic [1:0] s, input logic [1:0] d, input logic l,
                       input logic [15:0] a, input logic [15:0] b, input logic [3:0] i);
        req_valid   = 1'b1;
        req_sign    = imu_pkg::imu_sign_type'(s);
        req_dest    = imu_pkg::imu_dest_type'(d);
        req_use_lit = l;
        lit         = b[4:0];
        op_a        = a;
        op_b        = b;
        dst_idx     = i;
        req_acc_sel = i[0];
        flags_in    = a[7:0] ^ 8'hA5;
    endtask

    // judge the cycle after the request was taken
    task automatic chk(input logic [1:0] s, input logic [1:0] d, input logic l,
                       input logic [15:0] a, input logic [15:0] b, input logic [3:0] i);
        logic [39:0] p;
        p = ref_prod(s[1], s[0] & !l, a, l ? {11'h000, b[4:0]} : b);
        cmp(flags_out, a[7:0] ^ 8'hA5);
        cmp(flags_wr_en, 1'b0);
        cmp(wr_lo_en, d < 2'h2);
        cmp(wr_hi_en, d == 2'h0);
        cmp(acc_wr_en, d == 2'h3);
        if (d < 2'h2) begin
            cmp(wr_lo_idx, i);
            cmp(wr_lo_data, p[15:0]);
        end
        if (d == 2'h0) begin
            cmp(wr_hi_idx, 4'(i + 4'h1));
            cmp(wr_hi_data, p[31:16]);
        end
        if (d == 2'h3) begin
            cmp(acc_wr_sel, i[0]);
            cmp(acc_wr_data, p);
        end
    endtask

    // one instruction, then the pulse must be gone and the model must hold it
    task automatic one(input logic [1:0] s, input logic [1:0] d, input logic l,
                       input logic [15:0] a, input logic [15:0] b, input logic [3:0] i);
        logic [39:0] p;
        p = ref_prod(s[1], s[0] & !l, a, l ? {11'h000, b[4:0]} : b);
        @(posedge sys_clk) #1 put(s, d, l, a, b, i);
        @(posedge sys_clk) #1 req_valid = 1'b0;
        chk(s, d, l, a, b, i);
        @(posedge sys_clk) #1 cmp({wr_lo_en, wr_hi_en, acc_wr_en}, 3'h0);
        // the far side must now hold the reference product, not just the port value
        if (d < 2'h2) begin
            cmp(imu_regfile_model_i.regs[i], p[15:0]);
        end
        if (d == 2'h0) begin
            cmp(imu_regfile_model_i.regs[4'(i + 4'h1)], p[31:16]);
        end
        if (d == 2'h3) begin
            cmp(imu_regfile_model_i.accs[i[0]], p);
        end
    endtask

    task automatic test_reset;
        cmp({wr_lo_en, wr_hi_en, acc_wr_en, flags_wr_en}, 40'h0);
        cmp(flags_out, 40'h0);
        cmp(acc_wr_data, 40'h0);
        cmp(acc_wr_sel, 40'h0);
        cmp({wr_lo_idx, wr_hi_idx, wr_lo_data, wr_hi_data}, 40'h0);
        $display("test reset done");
    endtask

    task automatic test_pair;
        for (int s = 0; s < 4; s++) begin
            one(2'(s), 2'h0, 1'b0, 16'h8001, 16'hFFFE, 4'hF);
            one(2'(s), 2'h0, 1'b0, 16'h7FFF, 16'h8000, 4'h4);
        end
        $display("test pair done");
    endtask

    task automatic test_acc;
        for (int s = 0; s < 4; s++) begin
            one(2'(s), 2'h3, 1'b0, 16'hFFFF, 16'h8000, 4'(s));
        end
        // top product bit set with both unsigned: must still be zero-extended
        one(2'h0, 2'h3, 1'b0, 16'hFFFF, 16'hFFFF, 4'h1);
        $display("test acc done");
    endtask

    task automatic test_single;
        for (int s = 0; s < 4; s++) begin
            one(2'(s), 2'h1, 1'b0, 16'h8123, 16'hF00D, 4'h9);
        end
        // unused destination code: no write of any kind may follow
        one(2'h3, 2'h2, 1'b0, 16'h8123, 16'hF00D, 4'h9);
        $display("test single done");
    endtask

    task automatic test_lit;
        // source signed bit set on purpose: the literal must still count as unsigned
        one(2'h3, 2'h3, 1'b1, 16'h8000, 16'hFFFF, 4'h1);
        one(2'h0, 2'h3, 1'b1, 16'hFFFF, 16'h001F, 4'h0);
        one(2'h2, 2'h1, 1'b1, 16'hFFFE, 16'h0011, 4'h7);
        one(2'h0, 2'h1, 1'b1, 16'hFFFF, 16'h001F, 4'h2);
        $display("test literal done");
    endtask

    // back to back every cycle; the second answer must follow the first by one cycle
    task automatic test_b2b;
        @(posedge sys_clk) #1 put(2'h3, 2'h0, 1'b0, 16'hC000, 16'h0003, 4'h2);
        @(posedge sys_clk) #1 put(2'h1, 2'h3, 1'b0, 16'h1234, 16'hFFFF, 4'h1);
        chk(2'h3, 2'h0, 1'b0, 16'hC000, 16'h0003, 4'h2);
        @(posedge sys_clk) #1 req_valid = 1'b0;
        chk(2'h1, 2'h3, 1'b0, 16'h1234, 16'hFFFF, 4'h1);
        $display("test back to back done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        // idle inputs during reset, each set once
        req_valid   = 1'b0;
        req_sign    = imu_pkg::IMU_SGN_UU;
        req_dest    = imu_pkg::IMU_DST_PAIR;
        req_use_lit = 1'b0;
        lit         = 5'h00;
        op_a        = 16'h0000;
        op_b        = 16'h0000;
        dst_idx     = 4'h0;
        req_acc_sel = 1'b0;
        flags_in    = 8'h00;
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        test_reset();
        test_pair();
        test_acc();
        test_single();
        test_lit();
        test_b2b();
        finish_test();
    end
endmodule

`default_nettype wire
